// [pkg/rqf_pkg.sv]
// Overview of operation
// - Qualify when either match field equals opcode
// - No partial match combined across fields
// - Filter tracking-table entries with class and opcode
// - Core demand reads 0x100 to 0x102
// - Core prefetch reads 0x110 to 0x112, droppable
// - Optimized read 0x104/0x114, page walk 0x106
// - Uncached reads 0x105, 0x107, 0x10E
// - Streaming stores 0x10C, 0x10D, write-invalidate 0x10F
// - Line flushes 0x118, 0x11A, 0x11C
// - Evict writebacks 0x184 to 0x187, 0x18C
// - Own invalidate 0x188, speculative 0x18A
// - Cache prefetches 0x198 to 0x19A
// - Interrupts 0x1D9 to 0x1DB, locks 0x1DE/0x1DF
// - I/O requests 0x11E, 0x13C, 0x1A4, 0x1A8
// - Responses 0x000, 0x001, 0x026
// - Data responses 0x002, 0x003, 0x033
// - Pulls 0x004/0x034/0x005, forwards 0x023 to 0x025
// - Remote completions 0x006 to 0x009, 0x00B
// - Victims 0x01B/0x031, data 0x00C/0x01E/0x020
// - Remote snoops 0x700 to 0x705
// - Remote reads 0x500-0x505, 0x50C, 0x087, 0x050
// - Remote writebacks 0x400 to 0x404, 0x406, 0x407
// - Writeback extras 0x408, 0x40B, 0x40C, 0x40D
package rqf_pkg;

  localparam int OPC_W = 12;
  localparam int CLS_W = 3;

  typedef logic [OPC_W-1:0] rqf_opc_t;

  // Logical queue classes of the tracking table
  typedef enum logic [CLS_W-1:0] {
    RQF_CLS_CORE_REQ = 3'h0,
    RQF_CLS_RESP = 3'h1,
    RQF_CLS_PROBE = 3'h2,
    RQF_CLS_RREAD = 3'h3,
    RQF_CLS_RWB = 3'h4
  } rqf_cls_e;

  // One table entry as presented to the filter
  typedef struct packed {
    logic valid;
    rqf_cls_e cls;
    rqf_opc_t opc;
  } rqf_entry_s;

  // Match field as programmed by the counter controls
  typedef struct packed {
    logic enable;
    rqf_opc_t opc;
  } rqf_field_s;

  localparam rqf_opc_t OPC_RESET = 12'h000;

  // Core request class
  localparam rqf_opc_t OPC_OWNERSHIP_READ = 12'h100;
  localparam rqf_opc_t OPC_CODE_READ = 12'h101;
  localparam rqf_opc_t OPC_DATA_READ = 12'h102;
  localparam rqf_opc_t OPC_OPT_DATA_READ = 12'h104;
  localparam rqf_opc_t OPC_UC_CODE_READ = 12'h105;
  localparam rqf_opc_t OPC_PAGE_WALK_READ = 12'h106;
  localparam rqf_opc_t OPC_PARTIAL_UNCACHED_READ = 12'h107;
  localparam rqf_opc_t OPC_FULL_STREAMING_STORE = 12'h10C;
  localparam rqf_opc_t OPC_PARTIAL_STREAMING_STORE = 12'h10D;
  localparam rqf_opc_t OPC_FULL_UNCACHED_READ = 12'h10E;
  localparam rqf_opc_t OPC_PARTIAL_WRITE_INVALIDATE = 12'h10F;
  localparam rqf_opc_t OPC_OWNERSHIP_READ_PREF = 12'h110;
  localparam rqf_opc_t OPC_CODE_READ_PREF = 12'h111;
  localparam rqf_opc_t OPC_DATA_READ_PREF = 12'h112;
  localparam rqf_opc_t OPC_OPT_DATA_READ_PREF = 12'h114;
  localparam rqf_opc_t OPC_LINE_FLUSH = 12'h118;
  localparam rqf_opc_t OPC_LINE_FLUSH_OPT = 12'h11A;
  localparam rqf_opc_t OPC_LINE_WRITEBACK_KEEP = 12'h11C;
  localparam rqf_opc_t OPC_IO_CURRENT_READ = 12'h11E;
  localparam rqf_opc_t OPC_LINE_CLEANSE = 12'h13C;
  localparam rqf_opc_t OPC_MODIFIED_EVICT_INVALID = 12'h184;
  localparam rqf_opc_t OPC_MODIFIED_EVICT_EXCL = 12'h185;
  localparam rqf_opc_t OPC_CLEAN_EVICT_INVALID = 12'h186;
  localparam rqf_opc_t OPC_CLEAN_EVICT_KEEP = 12'h187;
  localparam rqf_opc_t OPC_OWN_INVALIDATE = 12'h188;
  localparam rqf_opc_t OPC_SPECULATIVE_OWN_INVALIDATE = 12'h18A;
  localparam rqf_opc_t OPC_SHARED_EVICT_INVALID = 12'h18C;
  localparam rqf_opc_t OPC_LLC_PREFETCH_OWNERSHIP = 12'h198;
  localparam rqf_opc_t OPC_LLC_PREFETCH_CODE = 12'h199;
  localparam rqf_opc_t OPC_LLC_PREFETCH_DATA = 12'h19A;
  localparam rqf_opc_t OPC_PUSH_HINT = 12'h1A4;
  localparam rqf_opc_t OPC_NEAR_OWN_INVALIDATE = 12'h1A8;
  localparam rqf_opc_t OPC_INT_LOGICAL = 12'h1D9;
  localparam rqf_opc_t OPC_INT_PHYSICAL = 12'h1DA;
  localparam rqf_opc_t OPC_INT_PRIORITY = 12'h1DB;
  localparam rqf_opc_t OPC_SPLIT_LOCK_START = 12'h1DE;
  localparam rqf_opc_t OPC_BUS_LOCK_START = 12'h1DF;

  // Response class
  localparam rqf_opc_t OPC_INVALID_RESPONSE = 12'h000;
  localparam rqf_opc_t OPC_SHARED_RESPONSE = 12'h001;
  localparam rqf_opc_t OPC_MODIFIED_DATA_RESPONSE = 12'h002;
  localparam rqf_opc_t OPC_INVALID_FWD_MODIFIED = 12'h003;
  localparam rqf_opc_t OPC_PULL_DATA = 12'h004;
  localparam rqf_opc_t OPC_BOGUS_PULL = 12'h005;
  localparam rqf_opc_t OPC_COMPLETION = 12'h006;
  localparam rqf_opc_t OPC_COMPLETION_FWD_CODE = 12'h007;
  localparam rqf_opc_t OPC_COMPLETION_FWD_EXCL = 12'h008;
  localparam rqf_opc_t OPC_COMPLETION_WITH_PULL = 12'h009;
  localparam rqf_opc_t OPC_COMPLETION_FWD_OWN = 12'h00B;
  localparam rqf_opc_t OPC_COHERENT_DATA_CMP = 12'h00C;
  localparam rqf_opc_t OPC_VICTIM_ENTRY = 12'h01B;
  localparam rqf_opc_t OPC_REMOTE_NC_DATA = 12'h01E;
  localparam rqf_opc_t OPC_REMOTE_COH_DATA = 12'h020;
  localparam rqf_opc_t OPC_INVALID_FWD_CLEAN = 12'h023;
  localparam rqf_opc_t OPC_SHARED_FWD_CLEAN = 12'h024;
  localparam rqf_opc_t OPC_FORWARD_CONFLICT = 12'h025;
  localparam rqf_opc_t OPC_UNKNOWN_STATE_RESPONSE = 12'h026;
  localparam rqf_opc_t OPC_LLC_VICTIM_ENTRY = 12'h031;
  localparam rqf_opc_t OPC_INVALID_FWD_MOD_PARTIAL = 12'h033;
  localparam rqf_opc_t OPC_PULL_DATA_PARTIAL = 12'h034;

  // Probe class
  localparam rqf_opc_t OPC_SNAPSHOT_SNOOP = 12'h700;
  localparam rqf_opc_t OPC_CODE_SNOOP = 12'h701;
  localparam rqf_opc_t OPC_DATA_SNOOP = 12'h702;
  localparam rqf_opc_t OPC_MIGRATORY_SNOOP = 12'h703;
  localparam rqf_opc_t OPC_INVALIDATE_OWN_SNOOP = 12'h704;
  localparam rqf_opc_t OPC_EXCLUSIVE_INVALIDATE_SNOOP = 12'h705;

  // Remote read class
  localparam rqf_opc_t OPC_REMOTE_CURRENT_READ = 12'h500;
  localparam rqf_opc_t OPC_REMOTE_CODE_READ = 12'h501;
  localparam rqf_opc_t OPC_REMOTE_DATA_READ = 12'h502;
  localparam rqf_opc_t OPC_REMOTE_MIGRATORY_READ = 12'h503;
  localparam rqf_opc_t OPC_REMOTE_INVALIDATE_OWN = 12'h504;
  localparam rqf_opc_t OPC_REMOTE_FLUSH_INVALIDATE = 12'h505;
  localparam rqf_opc_t OPC_READ_INVALIDATE = 12'h50C;
  localparam rqf_opc_t OPC_INVALIDATE_TO_EXCL = 12'h087;
  localparam rqf_opc_t OPC_INVALIDATE_TO_MOD = 12'h050;

  // Remote writeback class
  localparam rqf_opc_t OPC_REMOTE_MODIFIED_EVICT_INVALID = 12'h400;
  localparam rqf_opc_t OPC_REMOTE_EVICT_SHARED = 12'h401;
  localparam rqf_opc_t OPC_REMOTE_EVICT_EXCL = 12'h402;
  localparam rqf_opc_t OPC_NONSNOOP_WRITE = 12'h403;
  localparam rqf_opc_t OPC_EVICT_INVALID_PARTIAL = 12'h404;
  localparam rqf_opc_t OPC_EVICT_EXCL_PARTIAL = 12'h406;
  localparam rqf_opc_t OPC_NONSNOOP_WRITE_PARTIAL = 12'h407;
  localparam rqf_opc_t OPC_PUSH_TO_HOME = 12'h408;
  localparam rqf_opc_t OPC_FLUSH_HINT = 12'h40B;
  localparam rqf_opc_t OPC_CLEAN_EVICT_NOTICE = 12'h40C;
  localparam rqf_opc_t OPC_NONSNOOP_READ = 12'h40D;

  // Registered filter state
  typedef struct packed {
    logic qualified;
    logic hit_a;
    logic hit_b;
    logic known;
  } rqf_state_s;

  localparam rqf_state_s RQF_STATE_RESET = '0;

endpackage : rqf_pkg

// [src/rqf_filter.sv]
module rqf_filter
  import rqf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire rqf_entry_s entry,
  input wire rqf_field_s field_a,
  input wire rqf_field_s field_b,
  output logic qualified,
  output logic hit_a,
  output logic hit_b,
  output logic opc_known
);

  // ************************************************************
  // Class membership of a code
  // ************************************************************
  function automatic logic code_in_class(input rqf_cls_e c, input rqf_opc_t o);
    logic r;
    r = 1'b0;
    unique case (c)
      RQF_CLS_CORE_REQ:
        unique case (o)
          OPC_OWNERSHIP_READ, OPC_CODE_READ, OPC_DATA_READ: r = 1'b1;
          OPC_OWNERSHIP_READ_PREF, OPC_CODE_READ_PREF,
          OPC_DATA_READ_PREF: r = 1'b1;
          OPC_OPT_DATA_READ, OPC_OPT_DATA_READ_PREF,
          OPC_PAGE_WALK_READ: r = 1'b1;
          OPC_UC_CODE_READ, OPC_PARTIAL_UNCACHED_READ,
          OPC_FULL_UNCACHED_READ: r = 1'b1;
          OPC_FULL_STREAMING_STORE, OPC_PARTIAL_STREAMING_STORE,
          OPC_PARTIAL_WRITE_INVALIDATE: r = 1'b1;
          OPC_LINE_FLUSH, OPC_LINE_FLUSH_OPT,
          OPC_LINE_WRITEBACK_KEEP: r = 1'b1;
          OPC_MODIFIED_EVICT_INVALID, OPC_MODIFIED_EVICT_EXCL, OPC_CLEAN_EVICT_INVALID,
          OPC_CLEAN_EVICT_KEEP, OPC_SHARED_EVICT_INVALID: r = 1'b1;
          OPC_OWN_INVALIDATE, OPC_SPECULATIVE_OWN_INVALIDATE: r = 1'b1;
          OPC_LLC_PREFETCH_OWNERSHIP, OPC_LLC_PREFETCH_CODE,
          OPC_LLC_PREFETCH_DATA: r = 1'b1;
          OPC_INT_LOGICAL, OPC_INT_PHYSICAL, OPC_INT_PRIORITY,
          OPC_SPLIT_LOCK_START, OPC_BUS_LOCK_START: r = 1'b1;
          OPC_IO_CURRENT_READ, OPC_LINE_CLEANSE, OPC_PUSH_HINT,
          OPC_NEAR_OWN_INVALIDATE: r = 1'b1;
          default: r = 1'b0;
        endcase
      RQF_CLS_RESP:
        unique case (o)
          OPC_INVALID_RESPONSE, OPC_SHARED_RESPONSE,
          OPC_UNKNOWN_STATE_RESPONSE: r = 1'b1;
          OPC_MODIFIED_DATA_RESPONSE, OPC_INVALID_FWD_MODIFIED,
          OPC_INVALID_FWD_MOD_PARTIAL: r = 1'b1;
          OPC_PULL_DATA, OPC_PULL_DATA_PARTIAL, OPC_BOGUS_PULL, OPC_FORWARD_CONFLICT,
          OPC_INVALID_FWD_CLEAN, OPC_SHARED_FWD_CLEAN: r = 1'b1;
          OPC_COMPLETION, OPC_COMPLETION_FWD_CODE, OPC_COMPLETION_FWD_EXCL,
          OPC_COMPLETION_WITH_PULL, OPC_COMPLETION_FWD_OWN: r = 1'b1;
          OPC_VICTIM_ENTRY, OPC_LLC_VICTIM_ENTRY, OPC_COHERENT_DATA_CMP,
          OPC_REMOTE_NC_DATA, OPC_REMOTE_COH_DATA: r = 1'b1;
          default: r = 1'b0;
        endcase
      RQF_CLS_PROBE:
        r = (o >= OPC_SNAPSHOT_SNOOP) && (o <= OPC_EXCLUSIVE_INVALIDATE_SNOOP);
      RQF_CLS_RREAD:
        r = ((o >= OPC_REMOTE_CURRENT_READ) && (o <= OPC_REMOTE_FLUSH_INVALIDATE))
          || (o == OPC_READ_INVALIDATE) || (o == OPC_INVALIDATE_TO_EXCL)
          || (o == OPC_INVALIDATE_TO_MOD);
      RQF_CLS_RWB:
        unique case (o)
          OPC_REMOTE_MODIFIED_EVICT_INVALID, OPC_REMOTE_EVICT_SHARED,
          OPC_REMOTE_EVICT_EXCL, OPC_NONSNOOP_WRITE, OPC_EVICT_INVALID_PARTIAL,
          OPC_EVICT_EXCL_PARTIAL, OPC_NONSNOOP_WRITE_PARTIAL: r = 1'b1;
          OPC_PUSH_TO_HOME, OPC_FLUSH_HINT, OPC_CLEAN_EVICT_NOTICE,
          OPC_NONSNOOP_READ: r = 1'b1;
          default: r = 1'b0;
        endcase
      default: r = 1'b0;
    endcase
    return r;
  endfunction : code_in_class

  // ************************************************************
  // Match and register
  // ************************************************************
  rqf_state_s state_ff;
  rqf_state_s nxt_state;
  rqf_field_s fields [2];
  logic [1:0] field_hit;
  logic entry_known;

  assign fields[0] = field_a;
  assign fields[1] = field_b;
  // Full opcode and class must both agree
  assign entry_known = entry.valid && code_in_class(entry.cls, entry.opc);

  // Each field stands alone, so a split match never qualifies
  for (genvar g = 0; g < 2; g++)
  begin : g_field
    assign field_hit[g] = entry_known && fields[g].enable
      && (fields[g].opc == entry.opc);
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.known = entry_known;
    nxt_state.hit_a = field_hit[0];
    nxt_state.hit_b = field_hit[1];
    nxt_state.qualified = |field_hit;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_ff <= RQF_STATE_RESET;
    else if (ce)
      state_ff <= nxt_state;
  end

  assign qualified = state_ff.qualified;
  assign hit_a = state_ff.hit_a;
  assign hit_b = state_ff.hit_b;
  assign opc_known = state_ff.known;

endmodule : rqf_filter

// [verif/rqf_filter_properties.sv]
module rqf_filter_properties
  import rqf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire rqf_entry_s entry,
  input wire rqf_field_s field_a,
  input wire rqf_field_s field_b,
  input wire logic qualified,
  input wire logic hit_a,
  input wire logic hit_b,
  input wire logic opc_known
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_qual_is_or: assert property (qualified == (hit_a | hit_b))
    else $error("qualified differs from either hit");
  a_hit_a_exact: assert property (ce && !(field_a.enable && entry.valid &&
    field_a.opc == entry.opc) |=> !hit_a) else $error("hit_a without exact match");
  a_hit_b_exact: assert property (ce && !(field_b.enable && entry.valid &&
    field_b.opc == entry.opc) |=> !hit_b) else $error("hit_b without exact match");
  a_hit_needs_known: assert property ((hit_a || hit_b) |-> opc_known)
    else $error("hit on a code outside its class");
  a_invalid_quiet: assert property (ce && !entry.valid |=> !opc_known && !qualified)
    else $error("invalid entry qualified");
  a_dread_hits_b: assert property (ce && entry.valid && entry.cls == RQF_CLS_CORE_REQ &&
    entry.opc == OPC_DATA_READ && field_b.enable && field_b.opc == OPC_DATA_READ
    |=> hit_b && qualified) else $error("data read missed in second field");
  a_snoop_known: assert property (ce && entry.valid && entry.cls == RQF_CLS_PROBE &&
    entry.opc inside {[OPC_SNAPSHOT_SNOOP:OPC_EXCLUSIVE_INVALIDATE_SNOOP]} |=> opc_known)
    else $error("snoop code not recognised");
  a_cross_class: assert property (ce && entry.cls != RQF_CLS_CORE_REQ &&
    entry.opc[11:8] == 4'h1 |=> !opc_known) else $error("core code known in other class");
  a_hold_on_stall: assert property (!ce |=> $stable({qualified, hit_a, hit_b, opc_known}))
    else $error("outputs moved while stalled");
endmodule : rqf_filter_properties

// [verif/rqf_queue_model.sv]
module rqf_queue_model
  import rqf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire rqf_cls_e cls,
  input wire rqf_opc_t opc,
  output rqf_entry_s entry
);
  timeunit 1ns;
  timeprecision 1ns;
  rqf_opc_t last_ff;

  always_ff @(posedge mclk)
    if (rst)
      last_ff <= 12'h000;
    else if (push)
      last_ff <= opc;

  // Empty slot shows stale code inverted, so the filter cannot lean on it
  always_comb
    entry = push ? rqf_entry_s'{1'b1, cls, opc} : rqf_entry_s'{1'b0, cls, ~last_ff};
endmodule : rqf_queue_model

// [verif/rqf_filter_tb.sv]
module rqf_filter_tb
  import rqf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Code table: class nibble over opcode
  // ****************************************
  localparam rqf_field_s OFF = '0;
  localparam logic [15:0] CODES [85] = '{
    16'h0100, 16'h0101, 16'h0102, 16'h0104, 16'h0105, 16'h0106, 16'h0107, 16'h010C,
    16'h010D, 16'h010E, 16'h010F, 16'h0110, 16'h0111, 16'h0112, 16'h0114, 16'h0118,
    16'h011A, 16'h011C, 16'h011E, 16'h013C, 16'h0184, 16'h0185, 16'h0186, 16'h0187,
    16'h0188, 16'h018A, 16'h018C, 16'h0198, 16'h0199, 16'h019A, 16'h01A4, 16'h01A8,
    16'h01D9, 16'h01DA, 16'h01DB, 16'h01DE, 16'h01DF,
    16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1004, 16'h1005, 16'h1006, 16'h1007,
    16'h1008, 16'h1009, 16'h100B, 16'h100C, 16'h101B, 16'h101E, 16'h1020, 16'h1023,
    16'h1024, 16'h1025, 16'h1026, 16'h1031, 16'h1033, 16'h1034,
    16'h2700, 16'h2701, 16'h2702, 16'h2703, 16'h2704, 16'h2705,
    16'h3500, 16'h3501, 16'h3502, 16'h3503, 16'h3504, 16'h3505, 16'h350C, 16'h3087,
    16'h3050, 16'h4400, 16'h4401, 16'h4402, 16'h4403, 16'h4404, 16'h4406, 16'h4407,
    16'h4408, 16'h440B, 16'h440C, 16'h440D};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b0;
  logic push = 1'b0;
  rqf_cls_e cls = RQF_CLS_CORE_REQ;
  rqf_opc_t opc = 12'h000;
  rqf_field_s fa = '0;
  rqf_field_s fb = '0;
  rqf_entry_s entry;
  logic qualified, hit_a, hit_b, opc_known;
  wire logic [3:0] outs = {qualified, hit_a, hit_b, opc_known};
  int n_errors = 0;
  int total_checks = 0;

  always #20 mclk = ~mclk;

  rqf_queue_model rqf_queue_model_inst (.mclk(mclk), .rst(rst), .push(push), .cls(cls),
    .opc(opc), .entry(entry));
  rqf_filter rqf_filter_inst (.mclk(mclk), .rst(rst), .ce(ce), .entry(entry), .field_a(fa),
    .field_b(fb), .qualified(qualified), .hit_a(hit_a), .hit_b(hit_b), .opc_known(opc_known));

  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
      n_errors++;
    end
  endtask : chk

  // One entry per call; result lands on the edge that takes it
  task drive(input logic v, input logic [3:0] c, input rqf_opc_t o, input rqf_field_s a,
    input rqf_field_s b);
    @(posedge mclk);
    push <= v;
    cls <= rqf_cls_e'(c[2:0]);
    opc <= o;
    fa <= a;
    fb <= b;
    @(posedge mclk);
    #1;
  endtask : drive

  task t_codes();
    rqf_field_s m;
    for (int i = 0; i < 85; i++)
    begin
      m = '{1'b1, CODES[i][11:0]};
      drive(1'b1, CODES[i][15:12], CODES[i][11:0], i[0] ? OFF : m, i[0] ? m : OFF);
      chk("code table", outs, i[0] ? 4'hB : 4'hD);
    end
  endtask : t_codes

  task t_mismatch();
    drive(1'b1, 4'h1, 12'h102, '{1'b1, 12'h102}, OFF);
    chk("core code in response class", outs, 4'h0);
    drive(1'b1, 4'h0, 12'h000, '{1'b1, 12'h000}, OFF);
    chk("response code in core class", outs, 4'h0);
    drive(1'b1, 4'h5, 12'h102, '{1'b1, 12'h102}, OFF);
    chk("undefined class", outs, 4'h0);
    drive(1'b1, 4'h0, 12'h106, '{1'b1, 12'h104}, '{1'b1, 12'h102});
    chk("split match", outs, 4'h1);
    drive(1'b1, 4'h0, 12'h102, '{1'b0, 12'h102}, OFF);
    chk("disabled field", outs, 4'h1);
    drive(1'b1, 4'h0, 12'hEFF, '{1'b1, 12'hEFF}, OFF);
    chk("unlisted core code", outs, 4'h0);
    // Stale 0xEFF shows inverted as a listed core code on the empty slot
    drive(1'b0, 4'h0, 12'h102, '{1'b1, 12'h100}, '{1'b1, 12'h100});
    chk("empty slot", outs, 4'h0);
  endtask : t_mismatch

  task t_both_freeze_reset();
    drive(1'b1, 4'h0, 12'h102, '{1'b1, 12'h102}, '{1'b1, 12'h102});
    chk("both fields", outs, 4'hF);
    @(posedge mclk);
    ce <= 1'b0;
    opc <= 12'h101;
    repeat (2) @(posedge mclk);
    #1;
    chk("stall hold", outs, 4'hF);
    @(posedge mclk);
    ce <= 1'b1;
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    chk("mid-run reset", outs, 4'h0);
    @(posedge mclk);
    rst <= 1'b0;
    drive(1'b1, 4'h0, 12'h188, OFF, '{1'b1, 12'h188});
    chk("after reset", outs, 4'hB);
  endtask : t_both_freeze_reset

  task conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    ce <= 1'b1;
    t_codes();
    t_mismatch();
    t_both_freeze_reset();
    conclude();
  end

  // About 210 cycles expected; the 1000-cycle limit, near five times that, is a hang
  initial
  begin
    #40000;
    n_errors++;
    conclude();
  end
endmodule : rqf_filter_tb

bind rqf_filter rqf_filter_properties rqf_filter_properties_inst (.mclk(mclk), .rst(rst),
  .ce(ce), .entry(entry), .field_a(field_a), .field_b(field_b), .qualified(qualified),
  .hit_a(hit_a), .hit_b(hit_b), .opc_known(opc_known));
